// File: hrs_mem.sv
`timescale 1ns/10ps
`default_nettype none

package hrs_pkg;
   // Stack geometry.
   localparam int DEPTH = 16;
   localparam int PC_WIDTH = 15;
   localparam int INDEX_WIDTH = 4;
   localparam int PTR_WIDTH = 5;
   // Register port geometry.
   localparam int ADDR_WIDTH = 3;
   localparam int DATA_WIDTH = 8;
   // Register offsets.
   localparam logic [2:0] OFS_POINTER = 3'h0;
   localparam logic [2:0] OFS_TOS_LOW = 3'h1;
   localparam logic [2:0] OFS_TOS_HIGH = 3'h2;
   localparam logic [2:0] OFS_CONTROL = 3'h3;
   localparam logic [2:0] OFS_STATUS = 3'h4;
   localparam logic [2:0] OFS_MASK = 3'h5;
   // Field positions.
   localparam int BIT_FAULT_RESET_EN = 0;
   localparam int BIT_OVERFLOW = 0;
   localparam int BIT_UNDERFLOW = 1;
   localparam int TOS_HIGH_WIDTH = 7;
   // Reset values and pointer landmarks.
   localparam logic [4:0] PTR_EMPTY = 5'h1F;
   localparam logic [4:0] PTR_FULL = 5'h0F;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic CONTROL_RESET = 1'b1;
endpackage : hrs_pkg

// Return-address storage with registered, write-first read data.
module hrs_mem #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // Clock.
   input wire logic clk,
   // Write port.
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port.
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] store [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
   end

   // The bypass keeps the top-of-stack view current in the same cycle
   // that an entry is written at the selected index.
   always_ff @(posedge clk) begin
      if (wr_en && (wr_addr == rd_addr)) begin
         rd_data <= wr_data;
      end else begin
         rd_data <= store[rd_addr];
      end
   end
endmodule : hrs_mem

`default_nettype wire

// File: hrs_stack.sv
// Summary of operation
// - Sixteen entries of fifteen bits each.
// - Storage private, outside program and data space.
// - Push on call, indirect call, interrupt.
// - Pop on return, literal return, interrupt return.
// - Push and pop leave high latch alone.
// - Reset enable zero makes stack circular.
// - Seventeenth push overwrites first entry.
// - Overflow and underflow flags always set.
// - Top-of-stack pair readable and writable.
// - Pointer write moves the top-of-stack pair.
// - Pointer is five bits for fault detection.
// - Increment then write; read then decrement.
// - Pointer shows most recently used entry.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module hrs_stack (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST,
   // Core sequencer requests.
   input wire logic PUSH,
   input wire logic [hrs_pkg::PC_WIDTH-1:0] PUSH_PC,
   input wire logic POP,
   // Core sequencer answers.
   output logic [hrs_pkg::PC_WIDTH-1:0] RETURN_PC,
   output logic RETURN_VALID,
   output logic DEVICE_RESET,
   // Register port.
   input wire logic [hrs_pkg::ADDR_WIDTH-1:0] ADDR,
   input wire logic [hrs_pkg::DATA_WIDTH-1:0] WR_DATA,
   input wire logic WR,
   input wire logic RD,
   output logic [hrs_pkg::DATA_WIDTH-1:0] RD_DATA,
   // Interrupt.
   output logic IRQ
);
   import hrs_pkg::*;

   logic [PTR_WIDTH-1:0] stack_pointer;
   logic [PTR_WIDTH-1:0] next_stack_pointer;
   logic stack_fault_reset_enable;
   logic [1:0] status;
   logic [1:0] next_status;
   logic [1:0] mask;
   logic [PC_WIDTH-1:0] tos;
   logic [DATA_WIDTH-1:0] next_rd_data;

   // Register decode.
   wire wr_pointer = WR && (ADDR == OFS_POINTER);
   wire wr_tos_low = WR && (ADDR == OFS_TOS_LOW);
   wire wr_tos_high = WR && (ADDR == OFS_TOS_HIGH);
   wire wr_control = WR && (ADDR == OFS_CONTROL);
   wire wr_status = WR && (ADDR == OFS_STATUS);
   wire wr_mask = WR && (ADDR == OFS_MASK);

   // Core operations. A push beats a pop in the same cycle; software
   // pointer and top-of-stack writes yield to either, so a program that
   // moves the pointer with interrupts live may see its write lost.
   wire do_push = PUSH;
   wire do_pop = POP && !PUSH;
   wire core_busy = PUSH || POP;

   // The extra pointer bit lets a full stack and an empty one differ.
   wire overflow = do_push && (stack_pointer == PTR_FULL);
   wire underflow = do_pop && (stack_pointer == PTR_EMPTY);

   wire [PTR_WIDTH-1:0] ptr_inc = stack_pointer + 5'h01;
   wire [PTR_WIDTH-1:0] ptr_dec = stack_pointer - 5'h01;

   // Pointer first moves on a push, then the entry is written there.
   assign next_stack_pointer = do_push ? ptr_inc :
      do_pop ? ptr_dec :
      (wr_pointer ? WR_DATA[PTR_WIDTH-1:0] : stack_pointer);

   // Only the low four pointer bits index storage, so in circular mode
   // the seventeenth push lands on the entry of the first.
   wire [INDEX_WIDTH-1:0] wr_index = do_push ?
      ptr_inc[INDEX_WIDTH-1:0] : stack_pointer[INDEX_WIDTH-1:0];
   wire tos_sw_write = (wr_tos_low || wr_tos_high) && !core_busy;
   wire mem_wr = do_push || tos_sw_write;
   wire [PC_WIDTH-1:0] tos_merged = wr_tos_low ?
      {tos[PC_WIDTH-1:DATA_WIDTH], WR_DATA} :
      {WR_DATA[TOS_HIGH_WIDTH-1:0], tos[DATA_WIDTH-1:0]};
   wire [PC_WIDTH-1:0] mem_wdata = do_push ? PUSH_PC : tos_merged;

   // Storage has no address in program or data space; only the
   // top-of-stack pair reaches it.
   hrs_mem #(
      .WIDTH(PC_WIDTH),
      .DEPTH(DEPTH),
      .AW(INDEX_WIDTH)
   ) u_mem (
      .clk(CORE_CLK),
      .wr_en(mem_wr),
      .wr_addr(wr_index),
      .wr_data(mem_wdata),
      .rd_addr(next_stack_pointer[INDEX_WIDTH-1:0]),
      .rd_data(tos)
   );

   // Flags are raised whatever the reset enable says; a new event wins
   // over a write-one-to-clear in the same cycle.
   wire [1:0] status_set = {underflow, overflow};
   wire [1:0] status_clr = wr_status ? WR_DATA[1:0] : 2'h0;
   assign next_status = (status & ~status_clr) | status_set;

   // Read multiplexer; unmapped offsets read as zero.
   always_comb begin
      next_rd_data = 8'h00;
      if (RD) begin
         unique case (ADDR)
            OFS_POINTER: next_rd_data = {3'h0, stack_pointer};
            OFS_TOS_LOW: next_rd_data = tos[DATA_WIDTH-1:0];
            OFS_TOS_HIGH: next_rd_data = {1'b0, tos[PC_WIDTH-1:8]};
            OFS_CONTROL: next_rd_data = {7'h00, stack_fault_reset_enable};
            OFS_STATUS: next_rd_data = {6'h00, status};
            OFS_MASK: next_rd_data = {6'h00, mask};
            default: next_rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         stack_pointer <= PTR_EMPTY;
         status <= STATUS_RESET;
         mask <= MASK_RESET;
         stack_fault_reset_enable <= CONTROL_RESET;
      end else begin
         stack_pointer <= next_stack_pointer;
         status <= next_status;
         if (wr_mask) begin
            mask <= WR_DATA[1:0];
         end
         if (wr_control) begin
            stack_fault_reset_enable <= WR_DATA[BIT_FAULT_RESET_EN];
         end
      end
   end

   // The return value is taken from the top of stack before the
   // pointer drops. This block has no tie to the high latch, so push
   // and pop cannot disturb it.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         RETURN_PC <= 15'h0000;
         RETURN_VALID <= 1'b0;
      end else begin
         RETURN_VALID <= do_pop;
         if (do_pop) begin
            RETURN_PC <= tos;
         end
      end
   end

   // With the reset enable clear the stack simply wraps; with it set a
   // fault asks for a one-cycle device reset.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         DEVICE_RESET <= 1'b0;
      end else begin
         DEVICE_RESET <= stack_fault_reset_enable &&
            (overflow || underflow);
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         RD_DATA <= 8'h00;
         IRQ <= 1'b0;
      end else begin
         RD_DATA <= next_rd_data;
         IRQ <= |(next_status & mask);
      end
   end
endmodule : hrs_stack

`default_nettype wire

// File: hrs_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module hrs_core_model (
   // Clock.
   input wire logic CORE_CLK,
   // Stack answers.
   input wire logic [hrs_pkg::PC_WIDTH-1:0] RETURN_PC,
   // Stack requests.
   output logic PUSH,
   output logic [hrs_pkg::PC_WIDTH-1:0] PUSH_PC,
   output logic POP
);
   import hrs_pkg::*;
   initial begin
      PUSH = 1'b0;
      PUSH_PC = 15'h7FFF;
      POP = 1'b0;
   end
   // The bench moves the pointer only while no call is in flight.
   task automatic push(input logic [PC_WIDTH-1:0] pc);
      @(posedge CORE_CLK);
      PUSH <= 1'b1;
      PUSH_PC <= pc;
      @(posedge CORE_CLK);
      PUSH <= 1'b0;
      PUSH_PC <= ~pc;
   endtask : push
   task automatic pop(output logic [PC_WIDTH-1:0] pc);
      @(posedge CORE_CLK);
      POP <= 1'b1;
      @(posedge CORE_CLK);
      POP <= 1'b0;
      @(negedge CORE_CLK);
      pc = RETURN_PC;
   endtask : pop
endmodule : hrs_core_model
`default_nettype wire

// File: hrs_stack_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module hrs_stack_assertions (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST,
   // Core side.
   input wire logic PUSH,
   input wire logic POP,
   input wire logic [hrs_pkg::PC_WIDTH-1:0] RETURN_PC,
   input wire logic RETURN_VALID,
   input wire logic DEVICE_RESET,
   // Register side.
   input wire logic WR,
   input wire logic RD,
   input wire logic [hrs_pkg::DATA_WIDTH-1:0] RD_DATA,
   input wire logic IRQ
);
   import hrs_pkg::*;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   chk_pop_answer: assert property (POP && !PUSH |=> RETURN_VALID)
      else $error("pop not answered");
   chk_valid_cause: assert property (RETURN_VALID |-> $past(POP && !PUSH))
      else $error("answer without pop");
   chk_pc_change: assert property ($changed(RETURN_PC) |-> RETURN_VALID)
      else $error("return value moved");
   chk_push_silent: assert property (PUSH |=> !RETURN_VALID)
      else $error("push answered");
   chk_rd_idle: assert property (!$past(RD) |-> RD_DATA == 8'h00)
      else $error("read data outside slot");
   chk_fault_cause: assert property (DEVICE_RESET |->
      $past(PUSH || POP) || $past(PUSH || POP, 2))
      else $error("reset without stack op");
   chk_irq_cause: assert property ($rose(IRQ) |-> $past(PUSH || POP || WR))
      else $error("irq without cause");
   chk_irq_drop: assert property ($fell(IRQ) |-> $past(WR))
      else $error("irq dropped alone");
   cover property (RETURN_VALID);
   cover property (DEVICE_RESET);
   cover property ($rose(IRQ));
endmodule : hrs_stack_assertions
bind hrs_stack hrs_stack_assertions i_hrs_stack_assertions (
   .CORE_CLK(CORE_CLK), .RST(RST), .PUSH(PUSH), .POP(POP),
   .RETURN_PC(RETURN_PC), .RETURN_VALID(RETURN_VALID),
   .DEVICE_RESET(DEVICE_RESET), .WR(WR), .RD(RD), .RD_DATA(RD_DATA), .IRQ(IRQ));
`default_nettype wire

// File: test_hrs_stack.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_hrs_stack;
   import hrs_pkg::*;
   logic CORE_CLK = 1'b0;
   logic RST = 1'b1;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [2:0] ADDR = 3'h0;
   logic [7:0] WR_DATA = 8'h00;
   wire logic PUSH, POP, RETURN_VALID, DEVICE_RESET, IRQ;
   wire logic [14:0] PUSH_PC, RETURN_PC;
   wire logic [7:0] RD_DATA;
   logic [14:0] pc;
   int mismatches = 0;
   int tests_run = 0;
   int faults = 0;
   always #2 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) if (DEVICE_RESET === 1'b1) faults++;
   hrs_stack i_hrs_stack (.CORE_CLK(CORE_CLK), .RST(RST), .PUSH(PUSH),
      .PUSH_PC(PUSH_PC), .POP(POP), .RETURN_PC(RETURN_PC), .RD(RD),
      .RETURN_VALID(RETURN_VALID), .DEVICE_RESET(DEVICE_RESET), .WR(WR),
      .ADDR(ADDR), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .IRQ(IRQ));
   hrs_core_model i_hrs_core_model (.CORE_CLK(CORE_CLK), .POP(POP),
      .RETURN_PC(RETURN_PC), .PUSH(PUSH), .PUSH_PC(PUSH_PC));
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      ADDR <= a;
      WR_DATA <= d;
      WR <= 1'b1;
      @(posedge CORE_CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      @(negedge CORE_CLK);
      `CHK(RD_DATA, e)
   endtask : rd
   task automatic pop_chk(input logic [14:0] e);
      i_hrs_core_model.pop(pc);
      `CHK(RETURN_VALID, 1'b1)
      `CHK(pc, e)
   endtask : pop_chk
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic t_lifo;
      rd(OFS_POINTER, 8'h1F);
      rd(3'h6, 8'h00);
      i_hrs_core_model.push(15'h1357);
      i_hrs_core_model.push(15'h7ABC);
      rd(OFS_POINTER, 8'h01);
      rd(OFS_TOS_HIGH, 8'h7A);
      pop_chk(15'h7ABC);
      pop_chk(15'h1357);
      wr(OFS_POINTER, 8'h00);
      wr(OFS_TOS_LOW, 8'h34);
      wr(OFS_TOS_HIGH, 8'h12);
      pop_chk(15'h1234);
   endtask : t_lifo
   task automatic t_faults;
      wr(OFS_MASK, 8'h03);
      i_hrs_core_model.pop(pc);
      `CHK(IRQ, 1'b1)
      rd(OFS_POINTER, 8'h1E);
      `CHK(faults, 1)
      wr(OFS_STATUS, 8'h02);
      rd(OFS_STATUS, 8'h00);
      `CHK(IRQ, 1'b0)
      wr(OFS_POINTER, 8'h1F);
      wr(OFS_CONTROL, 8'h00);
      for (int i = 0; i < 17; i++) i_hrs_core_model.push(15'(i + 64));
      rd(OFS_STATUS, 8'h01);
      pop_chk(15'h0050);
      `CHK(faults, 1)
   endtask : t_faults
   initial begin
      #20000;
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge CORE_CLK);
      RST <= 1'b0;
      t_lifo();
      t_faults();
      wrap_up();
   end
endmodule : test_hrs_stack
`default_nettype wire
